// file: tw_far_slave.sv
// Purpose: far-side slave transmitter on the two-wire bus
// Assumes: open-drain wire with pull-up, seen as levels
// Notes: answers only its own read address; bytes come from tx_byte
`timescale 1ns/1ps
module tw_far_slave #(
  parameter logic [6:0] ADDR = 7'h3A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  output logic sda_low
);
  logic [7:0] a;
  logic ack_drv;
  logic sending;
  logic m;
  logic [2:0] idx;
  // released bits fall back to the pull-up level
  assign sda_low = ack_drv | (sending & ~tx_byte[idx]);
  initial begin
    ack_drv = 1'b0;
    sending = 1'b0;
    idx = 3'd7;
    forever begin
      @(negedge sda iff scl === 1'b1);
      repeat (8) @(posedge scl) a = {a[6:0], sda};
      if (a == {ADDR, 1'b1}) begin
        @(negedge scl) ack_drv = 1'b1;
        @(negedge scl) ack_drv = 1'b0;
        do begin
          sending = 1'b1;
          for (int k = 7; k >= 0; k--) begin
            idx = 3'(k);
            @(negedge scl);
          end
          sending = 1'b0;
          @(posedge scl) m = sda;
          @(negedge scl);
        end while (m == 1'b0);
      end
    end
  end
endmodule : tw_far_slave

// file: tw_map.svh
// Purpose: register offsets, field positions, reset values and timing for the two-wire block
// Assumes: 32-bit AHB-Lite words, one aligned word per register
// Notes: status codes are given with the prescaler bits at zero
`ifndef TW_MAP_SVH
`define TW_MAP_SVH

`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_DATA 8'h08
`define A_OWN 8'h0C

`define C_FLAG 7
`define C_ACK 6
`define C_STA 5
`define C_STO 4
`define C_WCOL 3
`define C_EN 2
`define C_IRQ 0
`define OWN_GCE 0

`define CTRL_RST 8'h00
`define STAT_RST 8'hF8
`define DATA_RST 8'hFF
`define OWN_RST 8'hFE

`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_MT_AACK 8'h18
`define ST_MT_ANAK 8'h20
`define ST_MT_DACK 8'h28
`define ST_MT_DNAK 8'h30
`define ST_LOST 8'h38
`define ST_MR_AACK 8'h40
`define ST_MR_ANAK 8'h48
`define ST_MR_DACK 8'h50
`define ST_MR_DNAK 8'h58
`define ST_SR_ADDR 8'h60
`define ST_SR_LADDR 8'h68
`define ST_SR_GC 8'h70
`define ST_SR_LGC 8'h78
`define ST_SR_DACK 8'h80
`define ST_SR_DNAK 8'h88
`define ST_GC_DACK 8'h90
`define ST_GC_DNAK 8'h98
`define ST_ST_ADDR 8'hA8
`define ST_ST_LADDR 8'hB0

`define CLK_NS 20
`define SCL_NS 10000
`define QTR_CYC ((`SCL_NS + 4 * `CLK_NS - 1) / (4 * `CLK_NS))

`endif

// file: tw_master_rx.sv
// Purpose: two-wire master receiver / slave receiver engine with AHB-Lite registers
// Assumes: open-drain pins, one bus clock rate, one AHB-Lite slave on the bus
// Notes: slave transmit is acknowledged and reported but sends no data
`timescale 1ns/1ps
`include "tw_map.svh"
module tw_master_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  input wire logic deep_sleep,
  output logic sda_oe,
  output logic wake
);
  import tw_pkg::*;

  localparam logic [7:0] QTR = 8'(`QTR_CYC);

  tw_pkg::eng_e state_r;
  logic [1:0] ph_r;
  logic [3:0] cnt_r;
  logic [7:0] qcnt_r;
  tw_pkg::byte_t shift_r, data_r, status_r, own_r, hrd_r;
  logic flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r, irq_en_r;
  logic [1:0] presc_r;
  logic rd_r, addr_ph_r, master_r, lost_r, gc_r, ackb_r, rep_r;
  logic scl_oe_r, sda_oe_r, stop_done_r, wake_r, busy_r;
  logic wr_pend_r, rd_pend_r, hready_r;
  logic [7:0] bus_a_r;
  logic [1:0] pin_s;
  logic scl_s, sda_s, scl_p, sda_p;
  logic scl_rise, scl_fall, start_det, stop_det, tick, addr_hit, accept;
  logic ctrl_wr, data_wr, own_wr, stat_wr, flag_clr;

  // open-drain: the pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign wake = wake_r;
  assign hrdata = {24'h000000, hrd_r};
  assign hreadyout = hready_r;
  assign hresp = 1'b0;

  function automatic tw_pkg::byte_t reg_rd(input logic [7:0] a);
    case (a)
      `A_CTRL: reg_rd = {flag_r, ack_en_r, start_r, stop_r, wcol_r, en_r, 1'b0, irq_en_r};
      `A_STAT: reg_rd = {status_r[7:3], 1'b0, presc_r};
      `A_DATA: reg_rd = data_r;
      `A_OWN: reg_rd = own_r;
      default: reg_rd = 8'h00;
    endcase
  endfunction : reg_rd

  function automatic tw_pkg::byte_t mack_code(input logic adr, input logic rd, input logic ack);
    if (adr) begin
      mack_code = rd ? (ack ? `ST_MR_AACK : `ST_MR_ANAK) : (ack ? `ST_MT_AACK : `ST_MT_ANAK);
    end else begin
      mack_code = rd ? (ack ? `ST_MR_DACK : `ST_MR_DNAK) : (ack ? `ST_MT_DACK : `ST_MT_DNAK);
    end
  endfunction : mack_code

  function automatic tw_pkg::byte_t sack_code(input logic adr, input logic dir, input logic lost,
                                              input logic gc, input logic ack);
    if (adr && dir) begin
      sack_code = lost ? `ST_ST_LADDR : `ST_ST_ADDR;
    end else if (adr) begin
      sack_code = gc ? (lost ? `ST_SR_LGC : `ST_SR_GC) : (lost ? `ST_SR_LADDR : `ST_SR_ADDR);
    end else begin
      sack_code = gc ? (ack ? `ST_GC_DACK : `ST_GC_DNAK) : (ack ? `ST_SR_DACK : `ST_SR_DNAK);
    end
  endfunction : sack_code

  function automatic logic slave_go(input tw_pkg::byte_t st);
    slave_go = (st == `ST_SR_ADDR) || (st == `ST_SR_LADDR) || (st == `ST_SR_GC) ||
               (st == `ST_SR_LGC) || (st == `ST_SR_DACK) || (st == `ST_GC_DACK);
  endfunction : slave_go

  task post(input tw_pkg::byte_t code);
    flag_r <= 1'b1;
    status_r <= code;
    state_r <= S_HOLD;
  endtask : post

  tw_sync2 u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_i({scl_i, sda_i}),
    .pin_s(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  assign start_det = scl_s && scl_p && sda_p && !sda_s;
  assign stop_det = scl_s && scl_p && !sda_p && sda_s;
  assign tick = (qcnt_r == 8'h00);
  assign addr_hit = ack_en_r && ((shift_r[7:1] == own_r[7:1]) ||
                    (own_r[`OWN_GCE] && shift_r[7:1] == 7'h00));

  // bus slave: writes take effect in the data phase; reads add one wait state
  // so a read right behind a write still sees the written value
  assign accept = hsel && hready && htrans[1];
  assign ctrl_wr = wr_pend_r && (bus_a_r == `A_CTRL);
  assign stat_wr = wr_pend_r && (bus_a_r == `A_STAT);
  assign data_wr = wr_pend_r && (bus_a_r == `A_DATA);
  assign own_wr = wr_pend_r && (bus_a_r == `A_OWN);
  assign flag_clr = ctrl_wr && hwdata[`C_FLAG];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hready_r <= 1'b1;
      bus_a_r <= 8'h00;
      hrd_r <= 8'h00;
    end else begin
      wr_pend_r <= accept && hwrite;
      rd_pend_r <= accept && !hwrite;
      hready_r <= !(accept && !hwrite);
      if (accept) begin
        bus_a_r <= haddr[7:0];
      end
      if (rd_pend_r) begin
        hrd_r <= reg_rd(bus_a_r);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_en_r <= 1'(`CTRL_RST >> `C_ACK);
      start_r <= 1'b0;
      stop_r <= 1'b0;
      en_r <= 1'b0;
      irq_en_r <= 1'b0;
      wcol_r <= 1'b0;
      own_r <= `OWN_RST;
      presc_r <= 2'h0;
    end else begin
      if (ctrl_wr) begin
        ack_en_r <= hwdata[`C_ACK];
        start_r <= hwdata[`C_STA];
        stop_r <= hwdata[`C_STO];
        en_r <= hwdata[`C_EN];
        irq_en_r <= hwdata[`C_IRQ];
      end else if (stop_done_r) begin
        stop_r <= 1'b0;
      end
      // data written while a transfer runs is a collision and is dropped
      if (data_wr) begin
        wcol_r <= !flag_r;
      end
      if (own_wr) begin
        own_r <= hwdata[7:0];
      end
      if (stat_wr) begin
        presc_r <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      busy_r <= 1'b0;
      qcnt_r <= 8'h00;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      qcnt_r <= tick ? (QTR - 8'h01) : (qcnt_r - 8'h01);
      if (!en_r) begin
        busy_r <= 1'b0;
      end else if (start_det) begin
        busy_r <= 1'b1;
      end else if (stop_det) begin
        busy_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_IDLE;
      ph_r <= 2'h0;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      data_r <= `DATA_RST;
      status_r <= `STAT_RST;
      flag_r <= 1'b0;
      rd_r <= 1'b0;
      addr_ph_r <= 1'b0;
      master_r <= 1'b0;
      lost_r <= 1'b0;
      gc_r <= 1'b0;
      ackb_r <= 1'b0;
      rep_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      stop_done_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      stop_done_r <= 1'b0;
      wake_r <= 1'b0;
      // a flag raised below in the same cycle overrides this clear
      if (flag_clr) begin
        flag_r <= 1'b0;
      end
      if (data_wr && flag_r) begin
        data_r <= hwdata[7:0];
      end
      if (!en_r) begin
        state_r <= S_IDLE;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
        master_r <= 1'b0;
      end else begin
        unique case (state_r)
          S_IDLE: begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            master_r <= 1'b0;
            if (start_r && !flag_r && !busy_r && tick) begin
              state_r <= S_START;
              ph_r <= 2'h0;
              rep_r <= 1'b0;
            end else if (start_det) begin
              state_r <= S_SBIT;
              cnt_r <= 4'h0;
              addr_ph_r <= 1'b1;
              lost_r <= 1'b0;
            end
          end
          S_START: if (tick) begin
            unique case (ph_r)
              2'h0: begin
                sda_oe_r <= 1'b0;
                ph_r <= 2'h1;
              end
              2'h1: begin
                scl_oe_r <= 1'b0;
                if (scl_s) ph_r <= 2'h2;
              end
              2'h2: begin
                sda_oe_r <= 1'b1;
                ph_r <= 2'h3;
              end
              2'h3: begin
                scl_oe_r <= 1'b1;
                master_r <= 1'b1;
                post(rep_r ? `ST_RSTART : `ST_START);
              end
            endcase
          end
          S_HOLD: if (!flag_r) begin
            ph_r <= 2'h0;
            cnt_r <= 4'h0;
            if (master_r) begin
              if (status_r == `ST_START || status_r == `ST_RSTART) begin
                shift_r <= data_r;
                rd_r <= data_r[0];
                addr_ph_r <= 1'b1;
                state_r <= S_MBIT;
              end else if (stop_r) begin
                state_r <= S_STOP;
              end else if (start_r) begin
                state_r <= S_START;
                rep_r <= 1'b1;
              end else begin
                shift_r <= rd_r ? 8'hFF : data_r;
                addr_ph_r <= 1'b0;
                state_r <= S_MBIT;
              end
            end else if (slave_go(status_r)) begin
              scl_oe_r <= 1'b0;
              addr_ph_r <= 1'b0;
              state_r <= S_SBIT;
            end else begin
              // lost, NAKed data or slave transmit; a pending start waits in idle for a free bus
              state_r <= S_IDLE;
            end
          end
          S_MBIT: if (tick) begin
            unique case (ph_r)
              2'h0: begin
                sda_oe_r <= (addr_ph_r || !rd_r) && !shift_r[7];
                ph_r <= 2'h1;
              end
              2'h1: begin
                scl_oe_r <= 1'b0;
                if (scl_s) ph_r <= 2'h2;
              end
              2'h2: begin
                shift_r <= {shift_r[6:0], sda_s};
                ph_r <= 2'h3;
                if (!sda_oe_r && (addr_ph_r || !rd_r) && !sda_s) begin
                  // another master won; keep following its bits as a slave
                  lost_r <= 1'b1;
                  master_r <= 1'b0;
                  cnt_r <= cnt_r + 4'h1;
                  state_r <= S_SBIT;
                end
              end
              2'h3: begin
                scl_oe_r <= 1'b1;
                cnt_r <= cnt_r + 4'h1;
                ph_r <= 2'h0;
                if (cnt_r == 4'h7) state_r <= S_MACK;
              end
            endcase
          end
          S_MACK: if (tick) begin
            unique case (ph_r)
              2'h0: begin
                sda_oe_r <= !addr_ph_r && rd_r && ack_en_r;
                ph_r <= 2'h1;
              end
              2'h1: begin
                scl_oe_r <= 1'b0;
                if (scl_s) ph_r <= 2'h2;
              end
              2'h2: begin
                ackb_r <= !sda_s;
                ph_r <= 2'h3;
                if (!sda_oe_r && rd_r && !addr_ph_r && !sda_s) begin
                  master_r <= 1'b0;
                  post(`ST_LOST);
                end
              end
              2'h3: begin
                scl_oe_r <= 1'b1;
                sda_oe_r <= 1'b0;
                if (rd_r && !addr_ph_r) data_r <= shift_r;
                post(mack_code(addr_ph_r, rd_r, ackb_r));
              end
            endcase
          end
          S_SBIT: begin
            if (stop_det) begin
              state_r <= S_IDLE;
            end else if (start_det) begin
              cnt_r <= 4'h0;
              addr_ph_r <= 1'b1;
              lost_r <= 1'b0;
            end else if (scl_rise && cnt_r != 4'h8) begin
              shift_r <= {shift_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              if (!addr_ph_r) begin
                sda_oe_r <= ack_en_r;
                ackb_r <= ack_en_r;
                state_r <= S_SACK;
              end else if (addr_hit) begin
                sda_oe_r <= 1'b1;
                ackb_r <= 1'b1;
                gc_r <= (shift_r[7:1] == 7'h00);
                state_r <= S_SACK;
              end else if (lost_r) begin
                post(`ST_LOST);
              end else begin
                state_r <= S_IDLE;
              end
            end
          end
          S_SACK: if (scl_fall) begin
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b1;
            addr_ph_r <= 1'b0;
            lost_r <= 1'b0;
            // in deep sleep a data byte is not kept; an address match pulses wake and still posts its status
            if (!addr_ph_r && !deep_sleep) data_r <= shift_r;
            if (addr_ph_r && deep_sleep) wake_r <= 1'b1;
            post(sack_code(addr_ph_r, shift_r[0], lost_r, gc_r, ackb_r));
          end
          S_STOP: if (tick) begin
            unique case (ph_r)
              2'h0: begin
                sda_oe_r <= 1'b1;
                ph_r <= 2'h1;
              end
              2'h1: begin
                scl_oe_r <= 1'b0;
                if (scl_s) ph_r <= 2'h2;
              end
              2'h2: begin
                sda_oe_r <= 1'b0;
                ph_r <= 2'h3;
              end
              2'h3: begin
                stop_done_r <= 1'b1;
                master_r <= 1'b0;
                state_r <= S_IDLE;
              end
            endcase
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule : tw_master_rx

// file: tw_master_rx_sva.sv
// Purpose: port checker for tw_master_rx
// Assumes: hready is tied to hreadyout, wire levels on scl_i
// Notes: a stretch is scl_oe high longer than any bit phase (300 cycles)
`timescale 1ns/1ps
`include "tw_map.svh"
module tw_master_rx_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic deep_sleep,
  input wire logic wake
);
  logic ctl_wr_r;
  logic [9:0] low_r;
  logic [9:0] age_r;
  logic clr_w;
  assign clr_w = ctl_wr_r & hwdata[`C_FLAG];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_wr_r <= 1'b0;
    end else begin
      ctl_wr_r <= hsel & htrans[1] & hwrite & hreadyout & (haddr[7:0] == `A_CTRL);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_r <= 10'h000;
    end else if (!scl_oe) begin
      low_r <= 10'h000;
    end else if (low_r != 10'h3FF) begin
      low_r <= low_r + 10'h001;
    end
  end
  // age since the last flag clear; saturates so old clears never excuse a release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age_r <= 10'h3FF;
    end else if (clr_w) begin
      age_r <= 10'h000;
    end else if (age_r != 10'h3FF) begin
      age_r <= age_r + 10'h001;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_read_wait: assert property (hsel && htrans[1] && !hwrite && hreadyout |=>
    !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hwrite && hreadyout |=>
    hreadyout) else $error("write stalled");
  a_start_hold: assert property ($rose(sda_oe) && scl_i |-> ##[1:400] scl_oe)
    else $error("no clock after start");
  a_stop_quiet: assert property ($fell(sda_oe) && scl_i |-> !scl_oe [*8])
    else $error("clock pulled right after stop");
  a_stretch_hold: assert property ($fell(scl_oe) && low_r >= 10'd300 |->
    age_r <= 10'd400) else $error("stretch released without flag clear");
  a_clear_release: assert property (clr_w && low_r >= 10'd300 |->
    ##[1:400] !scl_oe) else $error("clock kept after flag clear");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_wake_sleep: assert property (wake |-> $past(deep_sleep))
    else $error("wake outside deep sleep");
endmodule : tw_master_rx_sva
bind tw_master_rx tw_master_rx_sva tw_master_rx_sva_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hreadyout(hreadyout), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .deep_sleep(deep_sleep), .wake(wake));

// file: tw_pkg.sv
// Purpose: types shared by the two-wire block
// Assumes: constants live in tw_map.svh
// Notes: none
package tw_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_START = 4'h1,
    S_MBIT = 4'h2,
    S_MACK = 4'h3,
    S_HOLD = 4'h4,
    S_STOP = 4'h5,
    S_SBIT = 4'h6,
    S_SACK = 4'h7
  } eng_e;
endpackage : tw_pkg

// file: tw_sync2.sv
// Purpose: two-flop synchroniser for the bus clock and data pins
// Assumes: pins are asynchronous to hclk
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module tw_sync2 (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] pin_i,
  output logic [1:0] pin_s
);
  logic [1:0] meta_r;

  // idle bus level is high, so reset to ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 2'h3;
      pin_s <= 2'h3;
    end else begin
      meta_r <= pin_i;
      pin_s <= meta_r;
    end
  end
endmodule : tw_sync2

// file: two_wire_master_rx_slave_rx_tb_top.sv
// Purpose: self-checking bench for tw_master_rx
// Assumes: far slave at 7'h3A, bench master at a 160 ns bit clock
// Notes: software is slow on purpose so every flag shows a long stretch
`timescale 1ns/1ps
`include "tw_map.svh"
`define CHK(g, e) cmp(32'(g), 32'(e));
module two_wire_master_rx_slave_rx_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, scl_oe, sda_oe, wake, far_low, ak;
  logic deep_sleep = 1'b0;
  logic tb_scl_low = 1'b0;
  logic tb_sda_low = 1'b0;
  logic woke = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] q, v;
  logic [7:0] exp_q[$];
  logic [7:0] s_adr[6] = '{8'hA4, 8'h00, 8'h00, 8'hA4, 8'hA5, 8'hA4};
  logic [7:0] s_own[6] = '{8'hA4, 8'hA5, 8'hA4, 8'hA4, 8'hA4, 8'hA4};
  logic [7:0] s_ctl[6] = '{8'h44, 8'h44, 8'h44, 8'h04, 8'h44, 8'h44};
  logic [7:0] s_st[6] = '{8'h60, 8'h70, 8'h00, 8'h00, 8'hA8, 8'h60};
  logic [7:0] r_adr[5] = '{`A_CTRL, `A_STAT, `A_DATA, `A_OWN, 8'h10};
  logic [7:0] r_val[5] = '{`CTRL_RST, `STAT_RST, `DATA_RST, `OWN_RST, 8'h00};
  int fail_count = 0;
  int checks_done = 0;
  wire scl = ~(scl_oe | tb_scl_low);
  wire sda = ~(sda_oe | tb_sda_low | far_low);
  always #10 hclk = ~hclk;
  always @(posedge hclk) if (wake === 1'b1) woke <= 1'b1;
  tw_master_rx tw_master_rx_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .deep_sleep(deep_sleep), .sda_oe(sda_oe),
    .wake(wake));
  tw_far_slave tw_far_slave_i (.scl(scl), .sda(sda), .tx_byte(tx_byte), .sda_low(far_low));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata[7:0];
  endtask : bus
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask : chk_reg
  task automatic wait_flag();
    q = 8'h00;
    for (int n = 0; n < 5000 && q[`C_FLAG] !== 1'b1; n++) bus(1'b0, `A_CTRL, 8'h00);
    `CHK(q[`C_FLAG], 1'b1)
    // slow software: the stretch must outlast any bit phase
    repeat (320) @(posedge hclk);
  endtask : wait_flag
  task automatic bm_bit(input logic b, output logic r);
    tb_sda_low <= ~b;
    #40;
    tb_scl_low <= 1'b0;
    #1;
    for (int n = 0; n < 9000 && scl !== 1'b1; n++) #20;
    #40;
    r = sda;
    #40;
    tb_scl_low <= 1'b1;
    #40;
  endtask : bm_bit
  task automatic bm_byte(input logic [7:0] d);
    logic r;
    for (int k = 7; k >= 0; k--) bm_bit(d[k], r);
    bm_bit(1'b1, r);
    ak = ~r;
  endtask : bm_byte
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    #2_000_000;
    fail_count++;
    close_out();
  end
  initial begin
    q = 8'($urandom(7));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) chk_reg(r_adr[i], r_val[i]);
    bus(1'b1, `A_DATA, 8'h5A);
    chk_reg(`A_CTRL, 8'h08);
    chk_reg(`A_DATA, `DATA_RST);
    bus(1'b1, `A_CTRL, 8'hA4);
    wait_flag();
    chk_reg(`A_STAT, `ST_START);
    bus(1'b1, `A_DATA, {7'h3A, 1'b1});
    bus(1'b1, `A_CTRL, 8'hC4);
    wait_flag();
    chk_reg(`A_STAT, `ST_MR_AACK);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      tx_byte <= v;
      exp_q.push_back(v);
      bus(1'b1, `A_CTRL, (i < 2) ? 8'hC4 : 8'h84);
      wait_flag();
      chk_reg(`A_STAT, (i < 2) ? `ST_MR_DACK : `ST_MR_DNAK);
      chk_reg(`A_DATA, exp_q.pop_front());
    end
    bus(1'b1, `A_CTRL, 8'hA4);
    wait_flag();
    chk_reg(`A_STAT, `ST_RSTART);
    bus(1'b1, `A_DATA, {7'h3B, 1'b1});
    bus(1'b1, `A_CTRL, 8'h84);
    wait_flag();
    chk_reg(`A_STAT, `ST_MR_ANAK);
    bus(1'b1, `A_CTRL, 8'hA4);
    wait_flag();
    chk_reg(`A_STAT, `ST_RSTART);
    // write address after a repeated start must leave the receiver
    bus(1'b1, `A_DATA, {7'h3B, 1'b0});
    bus(1'b1, `A_CTRL, 8'h84);
    wait_flag();
    chk_reg(`A_STAT, `ST_MT_ANAK);
    bus(1'b1, `A_CTRL, 8'h94);
    q = 8'hFF;
    for (int n = 0; n < 3000 && q[`C_STO] !== 1'b0; n++) bus(1'b0, `A_CTRL, 8'h00);
    `CHK(q[`C_STO], 1'b0)
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `A_OWN, s_own[i]);
      bus(1'b1, `A_CTRL, s_ctl[i]);
      deep_sleep <= (i == 5);
      tb_scl_low <= 1'b0;
      tb_sda_low <= 1'b0;
      #200;
      tb_sda_low <= 1'b1;
      #80;
      tb_scl_low <= 1'b1;
      #40;
      bm_byte(s_adr[i]);
      // keep sleep up until the synchronised clock fall has reached the engine
      repeat (8) @(posedge hclk);
      deep_sleep <= 1'b0;
      `CHK(ak, s_st[i] != 8'h00)
      if (s_st[i] != 8'h00) begin
        wait_flag();
        `CHK(scl_oe, 1'b1)
        chk_reg(`A_STAT, s_st[i]);
        for (int j = 0; j < 2 && s_st[i] != `ST_ST_ADDR; j++) begin
          v = 8'($urandom);
          exp_q.push_back(v);
          bus(1'b1, `A_CTRL, (j == 0) ? 8'hC4 : 8'h84);
          bm_byte(v);
          `CHK(ak, j == 0)
          wait_flag();
          chk_reg(`A_STAT, s_st[i] + 8'h20 + 8'(8 * j));
          chk_reg(`A_DATA, exp_q.pop_front());
        end
        bus(1'b1, `A_CTRL, 8'hC4);
      end
      tb_sda_low <= 1'b1;
      #40;
      tb_scl_low <= 1'b0;
      #80;
      tb_sda_low <= 1'b0;
      #80;
    end
    `CHK(woke, 1'b1)
    close_out();
  end
endmodule : two_wire_master_rx_slave_rx_tb_top
